/* File: design/hjib_pkg.sv */
package hjib_pkg;
   // object indices
   localparam logic [15:0] IDX_HOMING_ACCEL = 16'h609A;
   localparam logic [15:0] IDX_JERK = 16'h60A4;
   localparam logic [15:0] IDX_INTERP_REC = 16'h60C1;
   localparam logic [15:0] IDX_INTERP_TIME = 16'h60C2;
   localparam logic [15:0] IDX_INTERP_CFG = 16'h60C4;
   // subindices
   localparam logic [7:0] SUB_1 = 8'h01;
   localparam logic [7:0] SUB_2 = 8'h02;
   localparam logic [7:0] SUB_3 = 8'h03;
   localparam logic [7:0] SUB_4 = 8'h04;
   localparam logic [7:0] SUB_5 = 8'h05;
   localparam logic [7:0] SUB_6 = 8'h06;
   // reset values
   localparam logic [31:0] RST_HOMING_ACCEL = 32'h000001F4;
   localparam logic [31:0] RST_JERK = 32'h000003E8;
   localparam logic [31:0] RST_DEMAND = 32'h00000000;
   localparam logic [7:0] RST_PERIOD = 8'h01;
   localparam logic [7:0] RST_TIME_EXP = 8'hFD;
   localparam logic [31:0] RST_CAPACITY = 32'h00000001;
   localparam logic [31:0] RST_COUNT = 32'h00000001;
   localparam logic [7:0] RST_LAYOUT = 8'h00;
   localparam logic [15:0] RST_SLOT = 16'h0001;
   localparam logic [7:0] RST_REC_BYTES = 8'h04;
   // codes
   localparam logic [7:0] LAYOUT_FIFO = 8'h00;
   localparam logic [7:0] LAYOUT_RING = 8'h01;
   localparam logic [7:0] FLUSH_CLEAR = 8'h00;
   localparam logic [7:0] FLUSH_ENABLE = 8'h01;
   localparam logic [31:0] JERK_UNLIMITED = 32'h00000000;
   // ramp segment select
   typedef enum logic [1:0] {
      HJIB_SEG_ACC_START = 2'h0,
      HJIB_SEG_BRK_START = 2'h1,
      HJIB_SEG_ACC_END = 2'h2,
      HJIB_SEG_BRK_END = 2'h3
   } hjib_seg_type;
   // homing states
   typedef enum logic [3:0] {
      HJIB_H_IDLE = 4'h1,
      HJIB_H_SWITCH = 4'h2,
      HJIB_H_REF = 4'h4,
      HJIB_H_DONE = 4'h8
   } hjib_home_type;
endpackage : hjib_pkg

/* File: design/hjib_buf2.sv */
`timescale 1ns/1ns
module hjib_buf2 #(
   parameter int WIDTH = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   initial begin
      if (WIDTH < 1) $error("WIDTH too small");
   end
   logic [WIDTH-1:0] mem_reg [2];
   logic wr_ptr_reg;
   logic rd_ptr_reg;
   logic [1:0] cnt_reg;
   logic push;
   logic pop;
   assign in_ready = (cnt_reg != 2'h2);
   assign out_valid = (cnt_reg != 2'h0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_reg[rd_ptr_reg];
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end
   always_ff @(posedge clk) begin
      if (rst || flush) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         cnt_reg <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
      end
   end
   never_over_a: assert property (@(posedge clk) disable iff (rst) cnt_reg <= 2'h2)
      else $error("buffer count above two");
endmodule : hjib_buf2

/* File: design/hjib_homing.sv */
`timescale 1ns/1ns
module hjib_homing
   import hjib_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic home_start,
   input wire logic switch_hit,
   input wire logic end_hit,
   input wire logic [31:0] speed_switch,
   input wire logic [31:0] speed_ref,
   // outputs
   output logic [31:0] speed_cmd,
   output logic ramp_en,
   output logic motor_run,
   output logic home_done
);
   hjib_home_type st_reg;
   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= HJIB_H_IDLE;
      end else begin
         unique case (st_reg)
            HJIB_H_IDLE: begin
               if (home_start) st_reg <= HJIB_H_SWITCH;
            end
            HJIB_H_SWITCH: begin
               if (end_hit) st_reg <= HJIB_H_DONE;
               else if (switch_hit) st_reg <= HJIB_H_REF;
            end
            HJIB_H_REF: begin
               if (end_hit) st_reg <= HJIB_H_DONE;
            end
            HJIB_H_DONE: begin
               if (home_start) st_reg <= HJIB_H_SWITCH;
            end
            default: st_reg <= HJIB_H_IDLE;
         endcase
      end
   end
   // ramp only at start, step changes otherwise
   always_ff @(posedge clk) begin
      if (rst) begin
         speed_cmd <= 32'h0;
         ramp_en <= 1'b0;
         motor_run <= 1'b0;
         home_done <= 1'b0;
      end else begin
         ramp_en <= (st_reg == HJIB_H_IDLE || st_reg == HJIB_H_DONE) && home_start;
         home_done <= (st_reg == HJIB_H_DONE);
         motor_run <= (st_reg == HJIB_H_SWITCH || st_reg == HJIB_H_REF) && !end_hit;
         if (end_hit || st_reg == HJIB_H_IDLE || st_reg == HJIB_H_DONE) begin
            speed_cmd <= home_start && !end_hit ? speed_switch : 32'h0;
         end else if (st_reg == HJIB_H_REF || switch_hit) begin
            speed_cmd <= speed_ref;
         end else begin
            speed_cmd <= speed_switch;
         end
      end
   end
   ramp_start_a: assert property (@(posedge clk) disable iff (rst)
      ramp_en |-> $past(home_start))
      else $error("ramp outside homing start");
   stop_now_a: assert property (@(posedge clk) disable iff (rst)
      end_hit && st_reg != HJIB_H_IDLE |=> !motor_run && speed_cmd == 32'h0)
      else $error("motor not halted at end");
   slow_now_a: assert property (@(posedge clk) disable iff (rst)
      st_reg == HJIB_H_SWITCH && switch_hit && !end_hit |=> speed_cmd == $past(speed_ref)
      && !ramp_en)
      else $error("no immediate slow speed");
   cov_home_c: cover property (@(posedge clk) st_reg == HJIB_H_REF ##[1:50] st_reg == HJIB_H_DONE);
endmodule : hjib_homing

/* File: design/hjib_top.sv */
`timescale 1ns/1ns
// Functional notes
// - homing acceleration ramp applied only when homing motion starts
// - reference switch hit: switch to low search speed immediately, no ramp
// - end position hit: halt motor immediately, no deceleration ramp
// - 32-bit read/write homing acceleration, reset 1F4 hex
// - zero jerk limit means unlimited jerk for that segment
// - four 32-bit jerk limits reset 3E8 hex, each to its segment
// - signed 32-bit interpolated demand position, reset zero
// - new demand position takes effect only at next sync instant; held for a later sync while the input buffer is full
// - cycle time is period value times ten to the time index
// - read-only record capacity, reads one after reset
// - read/write count of held records, reset one
// - layout zero is FIFO, layout one is ring
// - 16-bit next free slot position, reset one
// - write-only 8-bit record size in bytes, default four
// - flush zero discards buffer data, records, disables access
// - flush one enables input buffer access
// - first homing speed for switch search, second for reference search
module hjib_top
   import hjib_pkg::*;
#(
   parameter int CAPACITY = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // object access
   input wire logic obj_wr,
   input wire logic obj_rd,
   input wire logic [15:0] obj_index,
   input wire logic [7:0] obj_sub,
   input wire logic [31:0] obj_wdata,
   output logic [31:0] obj_rdata,
   output logic obj_ack,
   output logic obj_err,
   // homing
   input wire logic home_start,
   input wire logic switch_hit,
   input wire logic end_hit,
   input wire logic [31:0] speed_switch,
   input wire logic [31:0] speed_ref,
   output logic [31:0] home_speed_cmd,
   output logic home_ramp_en,
   output logic [31:0] home_ramp_accel,
   output logic motor_run,
   output logic home_done,
   // ramp jerk
   input wire logic [1:0] ramp_seg,
   output logic [31:0] jerk_limit,
   output logic jerk_unlimited,
   // interpolation
   input wire logic sync_pulse,
   input wire logic setpoint_ready,
   output logic setpoint_valid,
   output logic [31:0] setpoint_pos,
   output logic [31:0] demand_position,
   output logic [7:0] cycle_period,
   output logic [7:0] cycle_exponent,
   output logic queue_is_ring,
   output logic queue_access,
   output logic [7:0] record_bytes
);
   initial begin
      if (CAPACITY < 1 || CAPACITY > 65535) $error("CAPACITY out of range");
   end
   // ****************************************
   // decode
   // ****************************************
   function automatic logic hit(input logic [15:0] idx, input logic [7:0] sub,
                                input logic [15:0] wi, input logic [7:0] ws);
      hit = (idx == wi) && (sub == ws);
   endfunction : hit
   logic [31:0] homing_ramp_accel_reg;
   logic [31:0] jerk_reg [4];
   logic [31:0] demand_pending_reg;
   logic pending_reg;
   logic [31:0] interp_demand_position_reg;
   logic [7:0] interp_period_value_reg;
   logic [7:0] interp_time_exponent_reg;
   logic [31:0] record_count_reg;
   logic [7:0] queue_layout_select_reg;
   logic [15:0] next_free_slot_reg;
   logic [7:0] record_byte_size_reg;
   logic access_reg;
   logic flush_pulse;
   logic wr_demand;
   logic buf_in_ready;
   logic buf_out_valid;
   logic buf_push;
   logic buf_pop;
   logic known;
   logic [31:0] rd_next;
   assign wr_demand = obj_wr && hit(obj_index, obj_sub, IDX_INTERP_REC, SUB_1);
   assign flush_pulse = obj_wr && hit(obj_index, obj_sub, IDX_INTERP_CFG, SUB_6)
      && obj_wdata[7:0] == FLUSH_CLEAR;
   // ****************************************
   // parameter registers
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         homing_ramp_accel_reg <= RST_HOMING_ACCEL;
      end else if (obj_wr && hit(obj_index, obj_sub, IDX_HOMING_ACCEL, SUB_1)) begin
         homing_ramp_accel_reg <= obj_wdata;
      end
   end
   for (genvar g = 0; g < 4; g++) begin : g_jerk
      always_ff @(posedge clk) begin
         if (rst) begin
            jerk_reg[g] <= RST_JERK;
         end else if (obj_wr && hit(obj_index, obj_sub, IDX_JERK, 8'(g + 1))) begin
            jerk_reg[g] <= obj_wdata;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         interp_period_value_reg <= RST_PERIOD;
         interp_time_exponent_reg <= RST_TIME_EXP;
         queue_layout_select_reg <= RST_LAYOUT;
         record_byte_size_reg <= RST_REC_BYTES;
      end else if (obj_wr) begin
         if (hit(obj_index, obj_sub, IDX_INTERP_TIME, SUB_1)) begin
            interp_period_value_reg <= obj_wdata[7:0];
         end
         if (hit(obj_index, obj_sub, IDX_INTERP_TIME, SUB_2)) begin
            interp_time_exponent_reg <= obj_wdata[7:0];
         end
         if (hit(obj_index, obj_sub, IDX_INTERP_CFG, SUB_3)
             && (obj_wdata[7:0] == LAYOUT_FIFO || obj_wdata[7:0] == LAYOUT_RING)) begin
            queue_layout_select_reg <= obj_wdata[7:0];
         end
         if (hit(obj_index, obj_sub, IDX_INTERP_CFG, SUB_5)) begin
            record_byte_size_reg <= obj_wdata[7:0];
         end
      end
   end
   // ****************************************
   // access enable
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         access_reg <= 1'b0;
      end else if (obj_wr && hit(obj_index, obj_sub, IDX_INTERP_CFG, SUB_6)) begin
         if (obj_wdata[7:0] == FLUSH_ENABLE) access_reg <= 1'b1;
         else if (obj_wdata[7:0] == FLUSH_CLEAR) access_reg <= 1'b0;
      end
   end
   // ****************************************
   // demand position, taken at sync
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         demand_pending_reg <= RST_DEMAND;
         pending_reg <= 1'b0;
      end else if (flush_pulse) begin
         pending_reg <= 1'b0;
      end else if (wr_demand && access_reg) begin
         demand_pending_reg <= obj_wdata;
         pending_reg <= 1'b1;
      end else if (sync_pulse && buf_in_ready) begin
         pending_reg <= 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         interp_demand_position_reg <= RST_DEMAND;
      end else if (sync_pulse && pending_reg && buf_in_ready && !flush_pulse) begin
         interp_demand_position_reg <= demand_pending_reg;
      end
   end
   assign buf_push = sync_pulse && pending_reg && buf_in_ready && !flush_pulse;
   assign buf_pop = buf_out_valid && setpoint_ready;
   hjib_buf2 #(
      .WIDTH(32)
   ) u_buf (
      .clk(clk),
      .rst(rst),
      .flush(flush_pulse),
      .in_valid(sync_pulse && pending_reg && !flush_pulse),
      .in_ready(buf_in_ready),
      .in_data(demand_pending_reg),
      .out_valid(buf_out_valid),
      .out_ready(setpoint_ready),
      .out_data(setpoint_pos)
   );
   assign setpoint_valid = buf_out_valid;
   // ****************************************
   // record count and slot
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         record_count_reg <= RST_COUNT;
         next_free_slot_reg <= RST_SLOT;
      end else if (flush_pulse) begin
         record_count_reg <= 32'h0;
         next_free_slot_reg <= RST_SLOT;
      end else if (obj_wr && access_reg && hit(obj_index, obj_sub, IDX_INTERP_CFG, SUB_2)) begin
         record_count_reg <= obj_wdata;
      end else if (obj_wr && access_reg && hit(obj_index, obj_sub, IDX_INTERP_CFG, SUB_4)) begin
         next_free_slot_reg <= obj_wdata[15:0];
      end else if (buf_push && access_reg) begin
         if (record_count_reg < 32'(CAPACITY)) begin
            record_count_reg <= record_count_reg + 32'h1;
         end
         if (next_free_slot_reg >= 16'(CAPACITY)) begin
            // ring wraps, fifo saturates
            next_free_slot_reg <= queue_layout_select_reg == LAYOUT_RING ? RST_SLOT
               : next_free_slot_reg;
         end else begin
            next_free_slot_reg <= next_free_slot_reg + 16'h1;
         end
      end
   end
   // ****************************************
   // read mux
   // ****************************************
   always_comb begin
      known = 1'b1;
      rd_next = 32'h0;
      if (hit(obj_index, obj_sub, IDX_HOMING_ACCEL, SUB_1)) rd_next = homing_ramp_accel_reg;
      else if (hit(obj_index, obj_sub, IDX_JERK, SUB_1)) rd_next = jerk_reg[0];
      else if (hit(obj_index, obj_sub, IDX_JERK, SUB_2)) rd_next = jerk_reg[1];
      else if (hit(obj_index, obj_sub, IDX_JERK, SUB_3)) rd_next = jerk_reg[2];
      else if (hit(obj_index, obj_sub, IDX_JERK, SUB_4)) rd_next = jerk_reg[3];
      else if (hit(obj_index, obj_sub, IDX_INTERP_REC, SUB_1)) rd_next = interp_demand_position_reg;
      else if (hit(obj_index, obj_sub, IDX_INTERP_TIME, SUB_1))
         rd_next = {24'h0, interp_period_value_reg};
      else if (hit(obj_index, obj_sub, IDX_INTERP_TIME, SUB_2))
         rd_next = {24'h0, interp_time_exponent_reg};
      else if (hit(obj_index, obj_sub, IDX_INTERP_CFG, SUB_1)) rd_next = 32'(CAPACITY);
      else if (hit(obj_index, obj_sub, IDX_INTERP_CFG, SUB_2)) rd_next = record_count_reg;
      else if (hit(obj_index, obj_sub, IDX_INTERP_CFG, SUB_3))
         rd_next = {24'h0, queue_layout_select_reg};
      else if (hit(obj_index, obj_sub, IDX_INTERP_CFG, SUB_4))
         rd_next = {16'h0, next_free_slot_reg};
      else known = 1'b0;
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         obj_rdata <= 32'h0;
         obj_ack <= 1'b0;
         obj_err <= 1'b0;
      end else begin
         obj_ack <= obj_rd || obj_wr;
         obj_err <= obj_rd && !known;
         obj_rdata <= obj_rd ? rd_next : 32'h0;
      end
   end
   // ****************************************
   // homing and ramp outputs
   // ****************************************
   hjib_homing u_home (
      .clk(clk),
      .rst(rst),
      .home_start(home_start),
      .switch_hit(switch_hit),
      .end_hit(end_hit),
      .speed_switch(speed_switch),
      .speed_ref(speed_ref),
      .speed_cmd(home_speed_cmd),
      .ramp_en(home_ramp_en),
      .motor_run(motor_run),
      .home_done(home_done)
   );
   always_ff @(posedge clk) begin
      if (rst) begin
         jerk_limit <= RST_JERK;
         jerk_unlimited <= 1'b0;
      end else begin
         jerk_limit <= jerk_reg[ramp_seg];
         jerk_unlimited <= jerk_reg[ramp_seg] == JERK_UNLIMITED;
      end
   end
   assign home_ramp_accel = homing_ramp_accel_reg;
   assign demand_position = interp_demand_position_reg;
   assign cycle_period = interp_period_value_reg;
   assign cycle_exponent = interp_time_exponent_reg;
   assign queue_is_ring = queue_layout_select_reg == LAYOUT_RING;
   assign queue_access = access_reg;
   assign record_bytes = record_byte_size_reg;
   // ****************************************
   // checks
   // ****************************************
   sync_takeover_a: assert property (@(posedge clk) disable iff (rst)
      $changed(interp_demand_position_reg) |-> $past(sync_pulse))
      else $error("demand changed without sync");
   flush_clears_a: assert property (@(posedge clk) disable iff (rst)
      flush_pulse |=> record_count_reg == 32'h0 && !access_reg && !pending_reg)
      else $error("flush left data");
   enable_access_a: assert property (@(posedge clk) disable iff (rst)
      obj_wr && hit(obj_index, obj_sub, IDX_INTERP_CFG, SUB_6)
      && obj_wdata[7:0] == FLUSH_ENABLE |=> access_reg)
      else $error("access not enabled");
   blocked_write_a: assert property (@(posedge clk) disable iff (rst)
      !access_reg && !flush_pulse |=> $stable(record_count_reg))
      else $error("count changed while blocked");
   jerk_zero_a: assert property (@(posedge clk) disable iff (rst)
      jerk_reg[ramp_seg] == JERK_UNLIMITED |=> jerk_unlimited)
      else $error("zero jerk not unlimited");
   cap_read_a: assert property (@(posedge clk) disable iff (rst)
      obj_rd && hit(obj_index, obj_sub, IDX_INTERP_CFG, SUB_1) |=> obj_rdata == 32'(CAPACITY))
      else $error("capacity read wrong");
   cov_sync_c: cover property (@(posedge clk) wr_demand && access_reg ##[1:20] buf_push);
   cov_flush_c: cover property (@(posedge clk) access_reg ##1 flush_pulse);
   cov_stall_c: cover property (@(posedge clk) !buf_in_ready && sync_pulse);
   cov_drain_c: cover property (@(posedge clk) buf_pop ##1 !buf_out_valid);
endmodule : hjib_top

/* File: verif/hjib_host_model.sv */
`timescale 1ns/1ns
// **********************************
// host side of the object interface
// **********************************
module hjib_host_model (
   // clock
   input wire logic clk,
   // request
   output logic obj_wr,
   output logic obj_rd,
   output logic [15:0] obj_index,
   output logic [7:0] obj_sub,
   output logic [31:0] obj_wdata,
   // answer
   input wire logic [31:0] obj_rdata,
   input wire logic obj_ack,
   input wire logic obj_err
);
   initial begin
      obj_wr = 1'b0;
      obj_rd = 1'b0;
      obj_index = 16'h0000;
      obj_sub = 8'h00;
      obj_wdata = 32'h00000000;
   end
   // one request, answer sampled half a cycle after the taking edge
   task acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
            output logic [31:0] q, output logic a, output logic e);
      @(negedge clk);
      obj_wr = w;
      obj_rd = !w;
      obj_index = i;
      obj_sub = s;
      obj_wdata = d;
      @(negedge clk);
      q = obj_rdata;
      a = obj_ack;
      e = obj_err;
      obj_wr = 1'b0;
      obj_rd = 1'b0;
      obj_wdata = ~d;
   endtask : acc
   // time base kept in milliseconds
   task keep_ms;
      logic [31:0] q;
      logic a, e;
      acc(1'b1, 16'h60C2, 8'h02, 32'h000000FD, q, a, e);
   endtask : keep_ms
endmodule : hjib_host_model

/* File: verif/homing_jerk_interp_buffer_tb_top.sv */
`timescale 1ns/1ns
module homing_jerk_interp_buffer_tb_top;
   import hjib_pkg::*;
   // *******
   // signals
   // *******
   logic clk, rst, home_start, switch_hit, end_hit, sync_pulse, setpoint_ready;
   logic obj_wr, obj_rd, obj_ack, obj_err, home_ramp_en, motor_run, home_done;
   logic jerk_unlimited, setpoint_valid, queue_is_ring, queue_access;
   logic [15:0] obj_index;
   logic [7:0] obj_sub, cycle_period, cycle_exponent, record_bytes;
   logic [1:0] ramp_seg;
   logic [31:0] obj_wdata, obj_rdata, speed_switch, speed_ref, home_speed_cmd;
   logic [31:0] home_ramp_accel, jerk_limit, setpoint_pos, demand_position;
   int errors = 0;
   int compares = 0;
   int cycles = 0;
   hjib_top dut (.clk, .rst, .obj_wr, .obj_rd, .obj_index, .obj_sub, .obj_wdata, .obj_rdata,
      .obj_ack, .obj_err, .home_start, .switch_hit, .end_hit, .speed_switch, .speed_ref,
      .home_speed_cmd, .home_ramp_en, .home_ramp_accel, .motor_run, .home_done, .ramp_seg,
      .jerk_limit, .jerk_unlimited, .sync_pulse, .setpoint_ready, .setpoint_valid,
      .setpoint_pos, .demand_position, .cycle_period, .cycle_exponent, .queue_is_ring,
      .queue_access, .record_bytes);
   hjib_host_model host (.clk, .obj_wr, .obj_rd, .obj_index, .obj_sub, .obj_wdata,
      .obj_rdata, .obj_ack, .obj_err);
   // *******
   // helpers
   // *******
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
      logic [31:0] q;
      logic a, e;
      host.acc(1'b1, i, s, d, q, a, e);
      chk("wr_ack", {31'h0, a}, 32'h1);
   endtask : wr
   task rd(input string n, input logic [15:0] i, input logic [7:0] s, input logic [31:0] x,
           input logic xe);
      logic [31:0] q;
      logic a, e;
      host.acc(1'b0, i, s, 32'h0, q, a, e);
      chk("rd_err", {31'h0, e}, {31'h0, xe});
      if (!xe) chk(n, q, x);
   endtask : rd
   task sync;
      @(negedge clk);
      sync_pulse = 1'b1;
      @(negedge clk);
      sync_pulse = 1'b0;
   endtask : sync
   task pop;
      @(negedge clk);
      setpoint_ready = 1'b1;
      @(negedge clk);
      setpoint_ready = 0;
   endtask : pop
   // *********
   // scenarios
   // *********
   task t_reset;
      rd("hacc", IDX_HOMING_ACCEL, SUB_1, 32'h1F4, 1'b0);
      for (int k = 1; k < 5; k++) rd("jerk", IDX_JERK, k[7:0], 32'h3E8, 1'b0);
      rd("demand", IDX_INTERP_REC, SUB_1, 32'h0, 1'b0);
      rd("period", IDX_INTERP_TIME, SUB_1, 32'h1, 1'b0);
      rd("capacity", IDX_INTERP_CFG, SUB_1, 32'h1, 1'b0);
      rd("count", IDX_INTERP_CFG, SUB_2, 32'h1, 1'b0);
      rd("slot", IDX_INTERP_CFG, SUB_4, 32'h1, 1'b0);
      rd("recsize", IDX_INTERP_CFG, SUB_5, 32'h0, 1'b1);
      rd("unmapped", 16'h6000, 8'h00, 32'h0, 1'b1);
      chk("recbytes", {24'h0, record_bytes}, 32'h4);
   endtask : t_reset
   task t_regs;
      wr(IDX_HOMING_ACCEL, SUB_1, 32'hA5A5_0001);
      rd("hacc", IDX_HOMING_ACCEL, SUB_1, 32'hA5A5_0001, 1'b0);
      chk("hacc_port", home_ramp_accel, 32'hA5A5_0001);
      wr(IDX_INTERP_CFG, SUB_1, 32'h5);
      rd("capacity", IDX_INTERP_CFG, SUB_1, 32'h1, 1'b0);
      wr(IDX_INTERP_CFG, SUB_5, 32'h8);
      chk("recbytes", {24'h0, record_bytes}, 32'h8);
      wr(IDX_INTERP_TIME, SUB_1, 32'h5);
      chk("period", {24'h0, cycle_period}, 32'h5);
      chk("exponent", {24'h0, cycle_exponent}, 32'hFD);
      wr(IDX_INTERP_CFG, SUB_3, 32'h1);
      chk("ring", {31'h0, queue_is_ring}, 32'h1);
      wr(IDX_INTERP_CFG, SUB_3, 32'h2);
      chk("ring", {31'h0, queue_is_ring}, 32'h1);
      wr(IDX_INTERP_CFG, SUB_3, 32'h0);
      chk("ring", {31'h0, queue_is_ring}, 32'h0);
   endtask : t_regs
   task t_jerk;
      logic [31:0] ex [4];
      ex = '{32'h3E8, 32'h0, 32'h123, 32'h3E8};
      wr(IDX_JERK, SUB_2, 32'h0);
      wr(IDX_JERK, SUB_3, 32'h123);
      for (int k = 0; k < 4; k++) begin
         @(negedge clk);
         ramp_seg = k[1:0];
         @(negedge clk);
         chk("jerk", jerk_limit, ex[k]);
         chk("unlim", {31'h0, jerk_unlimited}, {31'h0, k == 1});
      end
   endtask : t_jerk
   task t_homing;
      @(negedge clk);
      home_start = 1'b1;
      @(negedge clk);
      home_start = 1'b0;
      chk("ramp", {31'h0, home_ramp_en}, 32'h1);
      chk("speed", home_speed_cmd, speed_switch);
      @(negedge clk);
      chk("run", {31'h0, motor_run}, 32'h1);
      chk("ramp", {31'h0, home_ramp_en}, 32'h0);
      switch_hit = 1'b1;
      @(negedge clk);
      switch_hit = 1'b0;
      chk("speed", home_speed_cmd, speed_ref);
      chk("ramp", {31'h0, home_ramp_en}, 32'h0);
      end_hit = 1'b1;
      @(negedge clk);
      end_hit = 1'b0;
      chk("run", {31'h0, motor_run}, 32'h0);
      chk("speed", home_speed_cmd, 32'h0);
      @(negedge clk);
      chk("done", {31'h0, home_done}, 32'h1);
   endtask : t_homing
   task t_interp;
      wr(IDX_INTERP_REC, SUB_1, 32'h55);
      sync();
      chk("demand", demand_position, 32'h0);
      chk("valid", {31'h0, setpoint_valid}, 32'h0);
      wr(IDX_INTERP_CFG, SUB_6, 32'h1);
      chk("access", {31'h0, queue_access}, 32'h1);
      wr(IDX_INTERP_CFG, SUB_2, 32'h0);
      rd("count", IDX_INTERP_CFG, SUB_2, 32'h0, 1'b0);
      wr(IDX_INTERP_REC, SUB_1, 32'hFFFF_FF9C);
      chk("demand", demand_position, 32'h0);
      sync();
      chk("demand", demand_position, 32'hFFFF_FF9C);
      chk("head", setpoint_pos, 32'hFFFF_FF9C);
      rd("count", IDX_INTERP_CFG, SUB_2, 32'h1, 1'b0);
      wr(IDX_INTERP_REC, SUB_1, 32'h7);
      sync();
      chk("head", setpoint_pos, 32'hFFFF_FF9C);
      pop();
      chk("head", setpoint_pos, 32'h7);
      chk("valid", {31'h0, setpoint_valid}, 32'h1);
      pop();
      chk("valid", {31'h0, setpoint_valid}, 32'h0);
      wr(IDX_INTERP_REC, SUB_1, 32'h9);
      sync();
      wr(IDX_INTERP_CFG, SUB_6, 32'h0);
      chk("valid", {31'h0, setpoint_valid}, 32'h0);
      chk("access", {31'h0, queue_access}, 32'h0);
      rd("count", IDX_INTERP_CFG, SUB_2, 32'h0, 1'b0);
      wr(IDX_INTERP_CFG, SUB_2, 32'h3);
      rd("count", IDX_INTERP_CFG, SUB_2, 32'h0, 1'b0);
      rd("slot", IDX_INTERP_CFG, SUB_4, 32'h1, 1'b0);
   endtask : t_interp
   // *******
   // run
   // *******
   task end_sim;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         end_sim();
      end
   end
   initial begin
      rst = 1'b1;
      {home_start, switch_hit, end_hit, sync_pulse, setpoint_ready} = 5'h00;
      ramp_seg = 2'h0;
      speed_switch = 32'h00000032;
      speed_ref = 32'h0000000A;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      host.keep_ms();
      t_reset();
      t_regs();
      t_jerk();
      t_homing();
      t_interp();
      end_sim();
   end
endmodule : homing_jerk_interp_buffer_tb_top
